// ---- hw/cdb_exec.sv ----
/*
 Execution unit for four instructions of an 8-bit core: compare-skip-less,
 decimal adjust, decrement file and decrement-skip-zero. One instruction
 cycle is four clocks (Q1..Q4). The fetch stage presents the opcode with
 i_instr_valid, held stable for the whole cycle starting at Q1. The data
 file answers o_file_rd on i_file_rdata within the clock of the read strobe.
 Assumes the surrounding core keeps carry and digit carry on its inputs.
*/
// Functional notes
// - Opcode upper byte 0x30 is compare-skip-less; lower byte is file address.
// - Unsigned file minus working register; skip only when file strictly smaller.
// - Skip discards prefetched instruction, runs a no-op cycle; two cycles total.
// - Decimal adjust is upper bits 0010111 plus steering bit, low byte file.
// - Decimal adjust corrects packed-BCD sum in working register.
// - Lower nibble plus 6 when above 9 or digit carry; only carry updated.
// - Steering 0 writes file and working register; 1 writes file only.
// - Decrement 0000011d subtracts one; d=0 to working register, d=1 file.
// - Decrement-skip-zero 0001011d decrements, skips when zero, flags untouched.
`timescale 1ns/1ps
`include "cdb_exec_map.svh"

module cdb_exec
   import cdb_exec_pkg::*;
(
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   // Instruction from fetch
   input  wire logic        i_instr_valid,
   input  wire logic [15:0] i_instr,
   // Status in
   input  wire logic        i_carry,
   input  wire logic        i_digit_carry,
   // Data file
   input  wire logic [7:0]  i_file_rdata,
   output logic             o_file_rd,
   output logic             o_file_we,
   output logic [7:0]       o_file_addr,
   output logic [7:0]       o_file_wdata,
   // Results
   output logic [7:0]       o_working_register,
   output logic             o_carry_we,
   output logic             o_carry,
   output logic             o_discard,
   output logic             o_phase_q1,
   output logic             o_busy
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   cdb_instr_t kind;

   always_comb
   begin
      kind = CDB_I_NONE;
      if (i_instr[15:8] == `CDB_OP_CMP_LESS)
         kind = CDB_I_CMPL;
      else if (i_instr[15:9] == `CDB_OP_DAW_HI7)
         kind = CDB_I_DAW;
      else if (i_instr[15:9] == `CDB_OP_DEC_HI7)
         kind = CDB_I_DEC;
      else if (i_instr[15:9] == `CDB_OP_DSZ_HI7)
         kind = CDB_I_DSZ;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase sequencer and execution state

   cdb_phase_t phase_q, phase_d;
   cdb_instr_t cur_q, cur_d;
   logic       sel_q, sel_d;
   logic       skip_cyc_q, skip_cyc_d;
   logic       skip_req_q, skip_req_d;
   logic [7:0] opnd_q, opnd_d;
   logic [7:0] res_q, res_d;
   logic [7:0] working_register_q, working_register_d;
   logic [7:0] addr_q, addr_d;
   logic       rd_q, rd_d;
   logic       we_q, we_d;
   logic [7:0] wdata_q, wdata_d;
   logic       cwe_q, cwe_d;
   logic       cout_q, cout_d;
   logic       disc_q, disc_d;
   logic       busy_q, busy_d;
   logic       phq1_q, phq1_d;

   logic       lo_hi, hi_hi, hi_fix;
   logic [3:0] lo_adj, hi_adj;
   logic [4:0] hi_sum;
   logic [7:0] dec_val;

   always_comb
   begin
      // Decimal adjust arithmetic on working register, decrement of file operand
      lo_hi  = working_register_q[3:0] > `CDB_NIB_LIMIT;
      hi_hi  = working_register_q[7:4] > `CDB_NIB_LIMIT;
      hi_fix = hi_hi | i_carry;
      lo_adj = (lo_hi | i_digit_carry) ? `CDB_ADJ_SIX : 4'h0;
      if (hi_fix && lo_hi)
         hi_adj = `CDB_ADJ_SEVEN;
      else if (hi_fix)
         hi_adj = `CDB_ADJ_SIX;
      else
         hi_adj = 4'h0;
      hi_sum  = {1'b0, working_register_q[7:4]} + {1'b0, hi_adj};
      dec_val = opnd_q - `CDB_ONE;
   end

   always_comb
   begin
      phase_d    = phase_q;
      cur_d      = cur_q;
      sel_d      = sel_q;
      skip_cyc_d = skip_cyc_q;
      skip_req_d = skip_req_q;
      opnd_d     = opnd_q;
      res_d      = res_q;
      working_register_d     = working_register_q;
      addr_d     = addr_q;
      rd_d       = 1'b0;
      we_d       = 1'b0;
      wdata_d    = wdata_q;
      cwe_d      = 1'b0;
      cout_d     = cout_q;
      disc_d     = 1'b0;
      busy_d     = busy_q;
      phq1_d     = 1'b0;
      unique case (phase_q)
         CDB_Q1:
         begin
            phase_d = CDB_Q2;
            if (skip_cyc_q)
               cur_d = CDB_I_NONE;
            else if (i_instr_valid)
            begin
               cur_d  = kind;
               sel_d  = i_instr[8];
               addr_d = i_instr[7:0];
               rd_d   = kind != CDB_I_NONE;
            end
            else
               cur_d = CDB_I_NONE;
            busy_d = skip_cyc_q | (i_instr_valid & (kind != CDB_I_NONE));
         end
         CDB_Q2:
         begin
            phase_d = CDB_Q3;
            opnd_d  = i_file_rdata;
         end
         CDB_Q3:
         begin
            phase_d    = CDB_Q4;
            skip_req_d = 1'b0;
            unique case (cur_q)
               CDB_I_CMPL: skip_req_d = opnd_q < working_register_q;
               CDB_I_DAW:  res_d = {hi_sum[3:0], working_register_q[3:0] + lo_adj};
               CDB_I_DEC:  res_d = dec_val;
               CDB_I_DSZ:
               begin
                  res_d      = dec_val;
                  skip_req_d = dec_val == `CDB_ZERO;
               end
               default:    res_d = res_q;
            endcase
         end
         CDB_Q4:
         begin
            phase_d    = CDB_Q1;
            phq1_d     = 1'b1;
            skip_cyc_d = skip_req_q;
            disc_d     = skip_req_q;
            skip_req_d = 1'b0;
            unique case (cur_q)
               CDB_I_DAW:
               begin
                  we_d    = 1'b1;
                  wdata_d = res_q;
                  cwe_d   = 1'b1;
                  cout_d  = hi_sum[4] | i_carry;
                  if (!sel_q)
                     working_register_d = res_q;
               end
               CDB_I_DEC, CDB_I_DSZ:
               begin
                  if (sel_q)
                  begin
                     we_d    = 1'b1;
                     wdata_d = res_q;
                  end
                  else
                     working_register_d = res_q;
               end
               default:    working_register_d = working_register_q;
            endcase
         end
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         phase_q    <= CDB_Q1;
         cur_q      <= CDB_I_NONE;
         sel_q      <= 1'b0;
         skip_cyc_q <= 1'b0;
         skip_req_q <= 1'b0;
         opnd_q     <= `CDB_ZERO;
         res_q      <= `CDB_ZERO;
         working_register_q     <= `CDB_WORKING_REGISTER_RST;
         addr_q     <= `CDB_ZERO;
         rd_q       <= 1'b0;
         we_q       <= 1'b0;
         wdata_q    <= `CDB_ZERO;
         cwe_q      <= 1'b0;
         cout_q     <= 1'b0;
         disc_q     <= 1'b0;
         busy_q     <= 1'b0;
         phq1_q     <= 1'b1;
      end
      else
      begin
         phase_q    <= phase_d;
         cur_q      <= cur_d;
         sel_q      <= sel_d;
         skip_cyc_q <= skip_cyc_d;
         skip_req_q <= skip_req_d;
         opnd_q     <= opnd_d;
         res_q      <= res_d;
         working_register_q     <= working_register_d;
         addr_q     <= addr_d;
         rd_q       <= rd_d;
         we_q       <= we_d;
         wdata_q    <= wdata_d;
         cwe_q      <= cwe_d;
         cout_q     <= cout_d;
         disc_q     <= disc_d;
         busy_q     <= busy_d;
         phq1_q     <= phq1_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   always_comb
   begin
      o_file_rd          = rd_q;
      o_file_we          = we_q;
      o_file_addr        = addr_q;
      o_file_wdata       = wdata_q;
      o_working_register = working_register_q;
      o_carry_we         = cwe_q;
      o_carry            = cout_q;
      o_discard          = disc_q;
      o_phase_q1         = phq1_q;
      o_busy             = busy_q;
   end

endmodule : cdb_exec

// ---- hw/cdb_exec_map.svh ----
/*
 Constants for the compare/decrement/decimal-adjust execution unit:
 opcode fields, encodings, nibble limits and correction values.
 Assumes inclusion by bare name from the checker and design file.
*/
`ifndef CDB_EXEC_MAP_SVH
`define CDB_EXEC_MAP_SVH

`define CDB_OP_CMP_LESS     8'h30
`define CDB_OP_DAW_HI7      7'h17
`define CDB_OP_DEC_HI7      7'h03
`define CDB_OP_DSZ_HI7      7'h0b
`define CDB_NIB_LIMIT       4'h9
`define CDB_ADJ_SIX         4'h6
`define CDB_ADJ_SEVEN       4'h7
`define CDB_ONE             8'h01
`define CDB_ZERO            8'h00
`define CDB_WORKING_REGISTER_RST        8'h00

`endif

// ---- hw/cdb_exec_pkg.sv ----
/*
 Types for the compare/decrement/decimal-adjust execution unit.
 Assumes cdb_exec_map.svh is on the include path.
*/
package cdb_exec_pkg;
   typedef enum logic [1:0]
   {
      CDB_Q1 = 2'b00,
      CDB_Q2 = 2'b01,
      CDB_Q3 = 2'b11,
      CDB_Q4 = 2'b10
   } cdb_phase_t;

   typedef enum logic [2:0]
   {
      CDB_I_NONE = 3'h0,
      CDB_I_CMPL = 3'h1,
      CDB_I_DAW  = 3'h2,
      CDB_I_DEC  = 3'h3,
      CDB_I_DSZ  = 3'h4
   } cdb_instr_t;
endpackage : cdb_exec_pkg

// ---- sim/cdb_exec_chk.sv ----
/*
 Port checker for cdb_exec.
 Assumes the bench binds it to cdb_exec and holds i_instr until the result.
*/
`timescale 1ns/1ps
`include "cdb_exec_map.svh"

module cdb_exec_chk
(
   // Clock and reset
   input wire logic        i_core_clk,
   input wire logic        i_sys_rst,
   // Watched ports
   input wire logic        i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [7:0]  i_file_rdata,
   input wire logic        o_file_rd,
   input wire logic        o_file_we,
   input wire logic [7:0]  o_working_register,
   input wire logic        o_carry_we,
   input wire logic        o_discard,
   input wire logic        o_phase_q1,
   input wire logic        o_busy
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   rd_take_a: assert property (o_file_rd |-> $past(o_phase_q1 && i_instr_valid) && o_busy)
      else $error("read without a taken opcode");
   rd_pulse_a: assert property (o_file_rd |=> !o_file_rd)
      else $error("read strobe longer than one clock");
   we_timing_a: assert property (o_file_we |-> $past(o_file_rd, 3))
      else $error("write not three clocks after read");
   cmp_nowrite_a: assert property (o_file_rd && $past(i_instr[15:8]) == `CDB_OP_CMP_LESS |-> ##3 !o_file_we)
      else $error("compare wrote the file");
   cmp_less_a: assert property (o_discard && $past(i_instr[15:8], 4) == `CDB_OP_CMP_LESS
      |-> $past(i_file_rdata, 3) < o_working_register)
      else $error("compare skipped without file below working register");
   disc_timing_a: assert property (o_discard |-> $past(o_file_rd, 3))
      else $error("discard not at result time");
   skip_idle_a: assert property (o_discard |=> (!o_file_rd && !o_file_we)[*4])
      else $error("activity inside skip cycle");
   skip_noflag_a: assert property (o_discard |-> !o_carry_we)
      else $error("skip instruction touched carry");
   daw_only_a: assert property (o_carry_we |-> o_file_we && $past(i_instr[15:9], 4) == `CDB_OP_DAW_HI7)
      else $error("carry write outside decimal adjust");

   cover property (o_discard);
   cover property (o_carry_we);
   cover property (o_file_we && !o_carry_we);
endmodule : cdb_exec_chk

// ---- sim/tb.sv ----
/*
 Self-checking bench for cdb_exec: one task runs a full instruction cycle.
 Assumes the package, map header and checker are compiled first.
*/
`timescale 1ns/1ps
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end

module tb;
   logic        i_core_clk, i_sys_rst, i_instr_valid, i_carry, i_digit_carry;
   logic [15:0] i_instr;
   logic [7:0]  i_file_rdata, o_file_addr, o_file_wdata, o_working_register;
   logic        o_file_rd, o_file_we, o_carry_we, o_carry, o_discard, o_phase_q1, o_busy;
   logic [8:0]  r;
   logic [7:0]  wv [4] = '{8'ha5, 8'h9a, 8'h3b, 8'h42};
   logic [3:0]  cv [4] = '{4'h0, 4'h2, 4'h5, 4'ha};
   int          n_mismatch, check_count;

   cdb_exec dut
   (
      .i_core_clk         (i_core_clk),
      .i_sys_rst          (i_sys_rst),
      .i_instr_valid      (i_instr_valid),
      .i_instr            (i_instr),
      .i_carry            (i_carry),
      .i_digit_carry      (i_digit_carry),
      .i_file_rdata       (i_file_rdata),
      .o_file_rd          (o_file_rd),
      .o_file_we          (o_file_we),
      .o_file_addr        (o_file_addr),
      .o_file_wdata       (o_file_wdata),
      .o_working_register (o_working_register),
      .o_carry_we         (o_carry_we),
      .o_carry            (o_carry),
      .o_discard          (o_discard),
      .o_phase_q1         (o_phase_q1),
      .o_busy             (o_busy)
   );

   initial
   begin
      i_core_clk = 0;
      forever #10 i_core_clk = ~i_core_clk;
   end

   ////////////////////////////////////////////////////////////
   // Expected decimal adjust: {carry, result}
   function automatic logic [8:0] adj(input logic [7:0] w, input logic c, dc);
      logic [4:0] h;
      logic [3:0] l;
      h = {1'b0, w[7:4]};
      if ((w[7:4] > 9 || c) && w[3:0] > 9) h = h + 5'h07;
      else if (w[7:4] > 9 || c) h = h + 5'h06;
      l = (w[3:0] > 9 || dc) ? w[3:0] + 4'h6 : w[3:0];
      return {h[4] | c, h[3:0], l};
   endfunction : adj

   task automatic ex(input logic [15:0] op, input logic [7:0] rd, input logic c, dc, we,
                     input logic [7:0] wd, w, input logic dis, ca);
      @(negedge i_core_clk);
      while (o_phase_q1 !== 1'b1) @(negedge i_core_clk);
      i_instr = op;
      i_instr_valid = 1;
      i_file_rdata = rd;
      i_carry = c;
      i_digit_carry = dc;
      @(negedge i_core_clk);
      i_instr_valid = 0;
      `CK("rd", op[15:8] != 8'hff, o_file_rd)
      if (op[15:8] != 8'hff) `CK("addr", op[7:0], o_file_addr)
      // Result pulses stand in the clock after the Q4 edge only
      repeat (3) @(negedge i_core_clk);
      `CK("we", we, o_file_we)
      if (we) `CK("wdata", wd, o_file_wdata)
      `CK("working_register", w, o_working_register)
      `CK("disc", dis, o_discard)
      `CK("cwe", op[15:9] == 7'h17, o_carry_we)
      if (op[15:9] == 7'h17) `CK("carry", ca, o_carry)
      if (dis)
      begin
         // Would load the working register if not ignored
         i_instr = 16'h0601;
         i_instr_valid = 1;
         repeat (4)
         begin
            @(negedge i_core_clk);
            `CK("skip", 2'b00, {o_file_rd, o_file_we})
         end
         i_instr_valid = 0;
         `CK("skipw", w, o_working_register)
      end
   endtask : ex

   task tally_and_finish;
      if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      {i_sys_rst, i_instr_valid, i_carry, i_digit_carry, i_instr, i_file_rdata} = {1'b1, 27'h0};
      repeat (5) @(negedge i_core_clk);
      i_sys_rst = 0;
      `CK("rst", 4'h2, {o_file_we, o_discard, o_phase_q1, |o_working_register})
      ex(16'h07aa, 8'h00, 0, 0, 1, 8'hff, 8'h00, 0, 0);
      ex(16'h0655, 8'h43, 0, 0, 0, 8'h00, 8'h42, 0, 0);
      ex(16'h3012, 8'h41, 1, 1, 0, 8'h00, 8'h42, 1, 0);
      ex(16'h3013, 8'h42, 0, 0, 0, 8'h00, 8'h42, 0, 0);
      ex(16'h30ff, 8'hc0, 0, 0, 0, 8'h00, 8'h42, 0, 0);
      ex(16'h1720, 8'h01, 0, 0, 1, 8'h00, 8'h42, 1, 0);
      ex(16'h1621, 8'h03, 0, 0, 0, 8'h00, 8'h02, 0, 0);
      ex(16'hff00, 8'h00, 0, 0, 0, 8'h00, 8'h02, 0, 0);
      for (int i = 0; i < 4; i++)
      begin
         ex(16'h0630, wv[i] + 8'h01, 0, 0, 0, 8'h00, wv[i], 0, 0);
         r = adj(wv[i], cv[i][2], cv[i][3]);
         ex({7'h17, cv[i][1], 8'h40}, 8'h00, cv[i][2], cv[i][3], 1, r[7:0],
            cv[i][1] ? wv[i] : r[7:0], 0, r[8]);
      end
      tally_and_finish();
   end

   initial
   begin
      #50000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : tb

bind cdb_exec cdb_exec_chk u_chk
(
   .i_core_clk         (i_core_clk),
   .i_sys_rst          (i_sys_rst),
   .i_instr_valid      (i_instr_valid),
   .i_instr            (i_instr),
   .i_file_rdata       (i_file_rdata),
   .o_file_rd          (o_file_rd),
   .o_file_we          (o_file_we),
   .o_working_register (o_working_register),
   .o_carry_we         (o_carry_we),
   .o_discard          (o_discard),
   .o_phase_q1         (o_phase_q1),
   .o_busy             (o_busy)
);
